// file: nrtp_cfg.svh
// Command codes, cycle counts and pin timing for the NAND host controller.
// Assumes a 100 MHz core clock; all timing counts are derived from that rate.
`ifndef NRTP_CFG_SVH
`define NRTP_CFG_SVH
`define NRTP_CMD_READ1     8'h00
`define NRTP_CMD_READ2     8'h30
`define NRTP_CMD_CBREAD2   8'h35
`define NRTP_CMD_RNDCOL1   8'h05
`define NRTP_CMD_RNDCOL2   8'he0
`define NRTP_CMD_TPRND1    8'h06
`define NRTP_CMD_STATUS    8'h70
`define NRTP_CMD_PLSTAT    8'h78
`define NRTP_CMD_PROG1     8'h80
`define NRTP_CMD_PLNEXT    8'h11
`define NRTP_CMD_PROG2     8'h10
`define NRTP_CMD_CPROG2    8'h15
`define NRTP_CMD_CBPROG1   8'h85
`define NRTP_CMD_ERASE1    8'h60
`define NRTP_CMD_ERASE2    8'hd0
`define NRTP_CMD_CACHE     8'h31
`define NRTP_CMD_CACHELAST 8'h3f
`define NRTP_CMD_ID        8'h90
`define NRTP_ADDR_FULL     3'h5
`define NRTP_ADDR_ROW      3'h3
`define NRTP_ADDR_COL      3'h2
`define NRTP_ADDR_ID       3'h1
`define NRTP_ID_BYTES      3'h5
`define NRTP_CLK_NS        10
`define NRTP_STROBE_NS     30
`define NRTP_STROBE_CYC    ((`NRTP_STROBE_NS + `NRTP_CLK_NS - 1) / `NRTP_CLK_NS)
`define NRTP_PAGE_BYTES    12'h840
`endif

// file: nrtp_pkg.sv
// Types shared by the NAND host controller and its strobe timer.
// Assumes nrtp_cfg.svh is on the include path.
package nrtp_pkg;
  typedef enum logic [3:0] {
    NRTP_OP_PAGEREAD, NRTP_OP_TPREAD, NRTP_OP_TPCBREAD, NRTP_OP_TPRNDCOL,
    NRTP_OP_PLSTAT, NRTP_OP_TPPROG, NRTP_OP_TPCPROG, NRTP_OP_TPCBPROG,
    NRTP_OP_TPERASE, NRTP_OP_RNDCOL, NRTP_OP_CACHE, NRTP_OP_CACHELAST,
    NRTP_OP_STATUS, NRTP_OP_REREAD, NRTP_OP_ID, NRTP_OP_READBYTE
  } nrtp_op_e;
  typedef logic [7:0] nrtp_byte_t;
endpackage

// file: nrtp_strobe_if.sv
// Handshake between the sequencer and the strobe timer.
// Assumes a single core clock shared by both ends.
interface nrtp_strobe_if;
  logic start;
  logic done;
  modport seq (output start, input done);
  modport tmr (input start, output done);
endinterface

// file: nrtp_strobe_timer.sv
// Times one strobe phase: done pulses a fixed count of cycles after start.
// Assumes start is a single-cycle pulse from logic on the same clock.
`include "nrtp_cfg.svh"
module nrtp_strobe_timer
  import nrtp_pkg::*;
(
  input wire logic    core_clk, // Core clock
  input wire logic    rst,      // Sync reset, high
  nrtp_strobe_if.tmr  stb       // Start/done pair
);
  logic [3:0] countReg;
  logic [3:0] countNext;
  logic       doneReg;
  logic       doneNext;

  always_comb begin
    countNext = countReg;
    doneNext  = 1'b0;
    if (stb.start) begin
      countNext = 4'(`NRTP_STROBE_CYC);
    end else if (countReg != 4'h0) begin
      countNext = countReg - 4'h1;
      doneNext  = (countReg == 4'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      countReg <= 4'h0;
      doneReg  <= 1'b0;
    end else begin
      countReg <= countNext;
      doneReg  <= doneNext;
    end
  end

  assign stb.done = doneReg;

  a_done_after_start: assert property (@(posedge core_clk) disable iff (rst)
    stb.start |-> ##(`NRTP_STROBE_CYC + 1) stb.done)
    else $error("strobe timer done late or missing");
endmodule

// file: nrtp_host.sv
// Host-side NAND sequencer: turns one operation request into command,
// address, data and read-strobe cycles and waits on ready/busy.
// Assumes the pins reach a NAND part; ready/busy has an external pull-up.
// Behaviour
// - Two-plane read: 00h, five addresses, 00h, five addresses, 30h; only when ready.
// - Two-plane copy-back read: same sequence, confirm 35h.
// - Two-plane random column: 06h, five addresses, E0h, after two-plane read.
// - Plane status select 78h with three addresses, allowed while busy.
// - Two-plane program: 80h, addr+data, 11h, 80h, addr+data, 10h or 15h.
// - Two-plane copy-back program: 85h, five addr, 11h, 80h, five addr, 10h.
// - Host takes copy-back source and destination planes from addrA and addrB without checking them.
// - Page read: 00h, five addresses, 30h.
// - After polling with 70h, reissue 00h before reading data.
// - Column jump: 05h, two column addresses, E0h.
// - 31h starts cache read; busy for first cache time.
// - Host issues 31h without tracking pages, so cached reads can cross a block boundary.
`include "nrtp_cfg.svh"
module nrtp_host
  import nrtp_pkg::*;
(
  input  wire logic        core_clk,     // Core clock, 100 MHz
  input  wire logic        rst,          // Sync reset, high
  input  wire logic        opValid,      // Operation request
  output logic             opReady,      // Sequencer idle
  input  wire nrtp_op_e    opCode,       // Operation to run
  input  wire logic [39:0] addrA,        // First address, column bytes low
  input  wire logic [39:0] addrB,        // Second-plane address
  input  wire logic [11:0] dataLen,      // Bytes to write or read
  input  wire logic        wrValid,      // Write byte available
  output logic             wrReady,      // Write byte taken
  input  wire nrtp_byte_t  wrData,       // Write byte
  output logic             rdValid,      // Read byte pulse
  output nrtp_byte_t       rdData,       // Read byte
  output logic             waitBusy,     // Waiting on ready/busy
  output logic             cmdLatch,     // Command latch enable pin
  output logic             addrLatch,    // Address latch enable pin
  output logic             chipEnable_n, // Chip enable pin
  output logic             writeStrobe_n, // Write strobe pin
  output logic             read_strobe_n, // Read strobe pin
  output nrtp_byte_t       ioOut,        // I/O bus out
  output logic             ioOe,         // I/O bus drive enable
  input  wire nrtp_byte_t  ioIn,         // I/O bus in
  input  wire logic        readyBusy_n   // Ready/busy pin, low busy
);
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA,
                            ST_BUSY} nrtp_state_e;
  nrtp_strobe_if stb();
  nrtp_strobe_timer u_tmr (.core_clk(core_clk), .rst(rst), .stb(stb));

  logic [2:0]  rbSync;
  logic        rbReady;
  nrtp_state_e stateReg, stateNext;
  nrtp_op_e    opReg, opNext;
  logic [2:0]  stepReg, stepNext;
  logic [2:0]  addrCntReg, addrCntNext;
  logic [11:0] byteCntReg, byteCntNext;
  logic        phaseReg, phaseNext;
  logic        busyWaitReg, busyWaitNext;
  logic        wrActReg, wrActNext;
  nrtp_byte_t  rdDataReg, rdDataNext;
  logic        rdValidReg, rdValidNext;
  logic        stbStart;

  // One element of a scripted sequence: command byte, address count, data flag
  typedef struct packed {
    logic       last;
    logic       isData;
    logic [2:0] nAddr;
    logic       useB;
    logic [7:0] cmd;
    logic       waitRb;
  } nrtp_step_s;

  function automatic nrtp_step_s stepOf(nrtp_op_e op, logic [2:0] s);
    nrtp_step_s r;
    r = '0;
    unique case (op)
      NRTP_OP_PAGEREAD: unique case (s)
        3'h0: r = '{1'b0, 1'b0, `NRTP_ADDR_FULL, 1'b0, `NRTP_CMD_READ1, 1'b0};
        default: r = '{1'b1, 1'b0, 3'h0, 1'b0, `NRTP_CMD_READ2, 1'b1};
      endcase
      NRTP_OP_TPREAD, NRTP_OP_TPCBREAD: unique case (s)
        3'h0: r = '{1'b0, 1'b0, `NRTP_ADDR_FULL, 1'b0, `NRTP_CMD_READ1, 1'b0};
        3'h1: r = '{1'b0, 1'b0, `NRTP_ADDR_FULL, 1'b1, `NRTP_CMD_READ1, 1'b0};
        default: r = '{1'b1, 1'b0, 3'h0, 1'b0, (op == NRTP_OP_TPREAD) ?
                       `NRTP_CMD_READ2 : `NRTP_CMD_CBREAD2, 1'b1};
      endcase
      NRTP_OP_TPRNDCOL: unique case (s)
        3'h0: r = '{1'b0, 1'b0, `NRTP_ADDR_FULL, 1'b0, `NRTP_CMD_TPRND1, 1'b0};
        default: r = '{1'b1, 1'b1, 3'h0, 1'b0, `NRTP_CMD_RNDCOL2, 1'b0};
      endcase
      NRTP_OP_PLSTAT:
        r = '{1'b1, 1'b1, `NRTP_ADDR_ROW, 1'b0, `NRTP_CMD_PLSTAT, 1'b0};
      NRTP_OP_TPPROG, NRTP_OP_TPCPROG, NRTP_OP_TPCBPROG: unique case (s)
        3'h0: r = '{1'b0, op != NRTP_OP_TPCBPROG, `NRTP_ADDR_FULL, 1'b0,
                    (op == NRTP_OP_TPCBPROG) ? `NRTP_CMD_CBPROG1 : `NRTP_CMD_PROG1, 1'b0};
        3'h1: r = '{1'b0, 1'b0, 3'h0, 1'b0, `NRTP_CMD_PLNEXT, 1'b1};
        3'h2: r = '{1'b0, op != NRTP_OP_TPCBPROG, `NRTP_ADDR_FULL, 1'b1,
                    `NRTP_CMD_PROG1, 1'b0};
        default: r = '{1'b1, 1'b0, 3'h0, 1'b0, (op == NRTP_OP_TPCPROG) ?
                       `NRTP_CMD_CPROG2 : `NRTP_CMD_PROG2, 1'b1};
      endcase
      NRTP_OP_TPERASE: unique case (s)
        3'h0: r = '{1'b0, 1'b0, `NRTP_ADDR_ROW, 1'b0, `NRTP_CMD_ERASE1, 1'b0};
        3'h1: r = '{1'b0, 1'b0, `NRTP_ADDR_ROW, 1'b1, `NRTP_CMD_ERASE1, 1'b0};
        default: r = '{1'b1, 1'b0, 3'h0, 1'b0, `NRTP_CMD_ERASE2, 1'b1};
      endcase
      NRTP_OP_RNDCOL: unique case (s)
        3'h0: r = '{1'b0, 1'b0, `NRTP_ADDR_COL, 1'b0, `NRTP_CMD_RNDCOL1, 1'b0};
        default: r = '{1'b1, 1'b1, 3'h0, 1'b0, `NRTP_CMD_RNDCOL2, 1'b0};
      endcase
      NRTP_OP_CACHE:
        r = '{1'b1, 1'b0, 3'h0, 1'b0, `NRTP_CMD_CACHE, 1'b1};
      NRTP_OP_CACHELAST:
        r = '{1'b1, 1'b0, 3'h0, 1'b0, `NRTP_CMD_CACHELAST, 1'b1};
      NRTP_OP_STATUS: r = '{1'b1, 1'b1, 3'h0, 1'b0, `NRTP_CMD_STATUS, 1'b0};
      NRTP_OP_REREAD:
        r = '{1'b1, 1'b1, 3'h0, 1'b0, `NRTP_CMD_READ1, 1'b0};
      NRTP_OP_ID:
        r = '{1'b1, 1'b1, `NRTP_ADDR_ID, 1'b0, `NRTP_CMD_ID, 1'b0};
      NRTP_OP_READBYTE: r = '{1'b1, 1'b1, 3'h0, 1'b0, 8'h00, 1'b0};
    endcase
    return r;
  endfunction

  nrtp_step_s cur;
  logic       isWrite;
  logic [39:0] addrSel;
  assign cur     = stepOf(opReg, stepReg);
  assign isWrite = (opReg == NRTP_OP_TPPROG) || (opReg == NRTP_OP_TPCPROG);
  assign addrSel = cur.useB ? addrB : addrA;

  // Three stages; the first is read only by the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rbSync <= 3'h7;
    end else begin
      rbSync <= {rbSync[1:0], readyBusy_n};
    end
  end

  logic rbStateReg, rbStateNext;
  always_comb begin
    rbStateNext = (rbSync[2] == rbSync[1]) ? rbSync[1] : rbStateReg;
  end

  assign rbReady = rbStateReg;

  always_comb begin
    stateNext    = stateReg;
    opNext       = opReg;
    stepNext     = stepReg;
    addrCntNext  = addrCntReg;
    byteCntNext  = byteCntReg;
    phaseNext    = phaseReg;
    busyWaitNext = busyWaitReg;
    wrActNext    = wrActReg;
    rdDataNext   = rdDataReg;
    rdValidNext  = 1'b0;
    stbStart     = 1'b0;
    unique case (stateReg)
      ST_IDLE: begin
        // Only status select (78h) or status read (70h) may start while busy; read path waits
        if (opValid && (rbReady || opCode == NRTP_OP_PLSTAT ||
                        opCode == NRTP_OP_STATUS)) begin
          opNext      = opCode;
          stepNext    = 3'h0;
          stateNext   = (opCode == NRTP_OP_READBYTE) ? ST_RDATA : ST_CMD;
          byteCntNext = dataLen;
          phaseNext   = 1'b0;
          stbStart    = 1'b1;
        end
      end
      ST_CMD, ST_ADDR: begin
        if (stb.done) begin
          if (!phaseReg) begin
            phaseNext = 1'b1;
            stbStart  = 1'b1;
          end else begin
            phaseNext = 1'b0;
            if (stateReg == ST_CMD && cur.nAddr != 3'h0) begin
              stateNext   = ST_ADDR;
              addrCntNext = 3'h0;
              stbStart    = 1'b1;
            end else if (stateReg == ST_ADDR && addrCntReg + 3'h1 < cur.nAddr) begin
              addrCntNext = addrCntReg + 3'h1;
              stbStart    = 1'b1;
            end else if (cur.isData && isWrite) begin
              stateNext = ST_WDATA;
            end else if (cur.last && cur.isData) begin
              stateNext = (byteCntReg == 12'h0) ? ST_IDLE : ST_RDATA;
              stbStart  = (byteCntReg != 12'h0);
            end else if (cur.waitRb) begin
              stateNext    = ST_BUSY;
              busyWaitNext = 1'b0;
            end else begin
              stateNext = cur.last ? ST_IDLE : ST_CMD;
              stepNext  = stepReg + 3'h1;
              stbStart  = !cur.last;
            end
          end
        end
      end
      ST_WDATA: begin
        // Strobe waits for a byte so the pins never latch stale data
        if (byteCntReg == 12'h0) begin
          stateNext   = ST_CMD;
          stepNext    = stepReg + 3'h1;
          byteCntNext = dataLen; // Second plane gets its own byte count
          stbStart    = 1'b1;
        end else if (stb.done && phaseReg) begin
          phaseNext   = 1'b0;
          wrActNext   = 1'b0;
          byteCntNext = byteCntReg - 12'h1;
        end else if (stb.done) begin
          phaseNext = 1'b1;
          stbStart  = 1'b1;
        end else if (!wrActReg && wrValid) begin
          wrActNext = 1'b1;
          stbStart  = 1'b1;
        end
      end
      ST_RDATA: begin
        if (stb.done && !phaseReg) begin
          rdDataNext  = ioIn;
          rdValidNext = 1'b1;
          phaseNext   = 1'b1;
          stbStart    = 1'b1;
        end else if (stb.done) begin
          phaseNext   = 1'b0;
          byteCntNext = byteCntReg - 12'h1;
          stateNext   = (byteCntReg <= 12'h1) ? ST_IDLE : ST_RDATA;
          stbStart    = (byteCntReg > 12'h1);
        end
      end
      ST_BUSY: begin
        // Wait for busy to assert, then for its release
        if (!rbReady) begin
          busyWaitNext = 1'b1;
        end else if (busyWaitReg) begin
          stateNext = cur.last ? ST_IDLE : ST_CMD;
          stepNext  = stepReg + 3'h1;
          stbStart  = !cur.last;
        end
      end
    endcase
  end

  assign stb.start = stbStart;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateReg    <= ST_IDLE;
      opReg       <= NRTP_OP_PAGEREAD;
      stepReg     <= 3'h0;
      addrCntReg  <= 3'h0;
      byteCntReg  <= 12'h0;
      phaseReg    <= 1'b0;
      busyWaitReg <= 1'b0;
      wrActReg    <= 1'b0;
      rdDataReg   <= 8'h00;
      rdValidReg  <= 1'b0;
      rbStateReg  <= 1'b1;
    end else begin
      stateReg    <= stateNext;
      opReg       <= opNext;
      stepReg     <= stepNext;
      addrCntReg  <= addrCntNext;
      byteCntReg  <= byteCntNext;
      phaseReg    <= phaseNext;
      busyWaitReg <= busyWaitNext;
      wrActReg    <= wrActNext;
      rdDataReg   <= rdDataNext;
      rdValidReg  <= rdValidNext;
      rbStateReg  <= rbStateNext;
    end
  end

  // Strobes are low in phase 0 of each cycle
  assign opReady       = (stateReg == ST_IDLE);
  assign waitBusy      = (stateReg == ST_BUSY);
  assign chipEnable_n  = (stateReg == ST_IDLE);
  assign cmdLatch      = (stateReg == ST_CMD);
  assign addrLatch     = (stateReg == ST_ADDR);
  assign writeStrobe_n = !((stateReg == ST_CMD || stateReg == ST_ADDR ||
                           (stateReg == ST_WDATA && wrActReg)) && !phaseReg);
  assign read_strobe_n = !(stateReg == ST_RDATA && !phaseReg);
  assign ioOe          = (stateReg == ST_CMD || stateReg == ST_ADDR || stateReg == ST_WDATA);
  assign ioOut         = (stateReg == ST_CMD) ? cur.cmd :
                         (stateReg == ST_ADDR) ? addrSel[{addrCntReg, 3'h0} +: 8] : wrData;
  assign wrReady       = (stateReg == ST_WDATA) && stb.done && phaseReg;
  assign rdValid       = rdValidReg;
  assign rdData        = rdDataReg;

  sequence s_busy_seen;
    waitBusy && busyWaitReg;
  endsequence
  sequence s_ready_back;
    rbReady;
  endsequence

  a_busy_no_start: assert property (@(posedge core_clk) disable iff (rst)
    opValid && opReady && !rbReady && opCode == NRTP_OP_PAGEREAD |=> opReady)
    else $error("read started while busy");
  a_plstat_busy: assert property (@(posedge core_clk) disable iff (rst)
    opValid && opReady && opCode == NRTP_OP_PLSTAT |=> cmdLatch)
    else $error("status select not taken");
  a_busy_wait: assert property (@(posedge core_clk) disable iff (rst)
    waitBusy && !rbReady |=> waitBusy)
    else $error("left busy wait early");
  a_busy_release: assert property (@(posedge core_clk) disable iff (rst)
    s_busy_seen ##0 s_ready_back |=> !waitBusy)
    else $error("busy wait not left on ready");
  a_read_pulse: assert property (@(posedge core_clk) disable iff (rst)
    rdValid |-> $past(stateReg) == ST_RDATA)
    else $error("read byte outside read phase");
  a_oe_only_write: assert property (@(posedge core_clk) disable iff (rst)
    !read_strobe_n |-> !ioOe)
    else $error("bus driven during read strobe");
  a_cmd_addr_excl: assert property (@(posedge core_clk) disable iff (rst)
    !(cmdLatch && addrLatch))
    else $error("both latches high");
  a_addr_count: assert property (@(posedge core_clk) disable iff (rst)
    addrLatch |-> addrCntReg < cur.nAddr)
    else $error("address count overrun");
  a_idle_ce: assert property (@(posedge core_clk) disable iff (rst)
    opReady |-> chipEnable_n && writeStrobe_n && read_strobe_n)
    else $error("strobes active while idle");
endmodule

// file: nrtp_nand_model.sv
// Behavioural NAND device on the far side of nrtp_host: pins, busy, status, id.
// Assumes nrtp_host strobes; cycles are latched on the write strobe rising edge.
module nrtp_nand_model
  import nrtp_pkg::*;
#(
  parameter logic [39:0] ID_CODE = 40'h0102030405, // Arbitrary identifier value
  parameter int          ARR_NS  = 1500,           // Array to data register
  parameter int          CB_NS   = 300             // Cache move, short busy
)(
  input  wire logic       cmdLatch,      // Command cycle
  input  wire logic       addrLatch,     // Address cycle
  input  wire logic       chipEnable_n,  // Select
  input  wire logic       writeStrobe_n, // Write strobe
  input  wire logic       read_strobe_n, // Read strobe
  input  wire nrtp_byte_t ioOut,         // Bus from host
  input  wire logic       holdBusy,      // Bench-forced busy
  output nrtp_byte_t      ioIn,          // Bus to host
  output logic            readyBusy_n    // Open drain with pull-up
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0]  seqLog[$];
  logic [39:0] addrBuf;
  logic [11:0] col, startCol;
  logic [15:0] dataPage, outPage;
  int          aIdx, busyN, idIdx, mode;
  realtime     arrayDone, dly;
  initial begin
    aIdx = 0;
    busyN = 0;
    mode = 0;
    col = 12'h000;
    startCol = 12'h000;
    dataPage = 16'h0000;
    outPage = 16'h0000;
    arrayDone = 0;
    ioIn = 8'h00;
  end
  assign readyBusy_n = (busyN == 0) && !holdBusy;
  function automatic nrtp_byte_t datByte(logic [15:0] p, logic [11:0] c);
    return nrtp_byte_t'(p[7:0] * 8'd29) ^ c[7:0] ^ {c[11:8], 4'h0};
  endfunction
  task automatic goBusy(realtime d);
    busyN++;
    fork
      #d busyN--;
    join_none
  endtask
  always @(posedge writeStrobe_n) begin
    if (!chipEnable_n && cmdLatch) begin
      seqLog.push_back({2'b10, ioOut});
      dly = (arrayDone > $realtime) ? arrayDone - $realtime + CB_NS : CB_NS;
      case (ioOut)
        8'h00: begin
          mode = 0;
          col = startCol;
        end
        8'h30: begin
          col = addrBuf[11:0];
          startCol = col;
          outPage = addrBuf[31:16];
          dataPage = outPage;
          goBusy(ARR_NS);
        end
        8'h35: goBusy(ARR_NS);
        8'he0: begin
          col = addrBuf[11:0];
          if (aIdx == 5) outPage = addrBuf[31:16];
        end
        8'h70, 8'h78: mode = 1;
        8'h90: begin
          mode = 2;
          idIdx = 0;
        end
        8'h31, 8'h3f: begin
          outPage = dataPage;
          col = 12'h000;
          mode = 0;
          if (ioOut == 8'h31) begin
            dataPage++;
            arrayDone = $realtime + dly + ARR_NS;
          end
          goBusy(dly);
        end
        8'h11, 8'h10, 8'h15, 8'hd0: goBusy(CB_NS);
        default: ;
      endcase
      aIdx = 0;
    end else if (!chipEnable_n && addrLatch) begin
      seqLog.push_back({2'b01, ioOut});
      if (aIdx < 5) addrBuf[8*aIdx +: 8] = ioOut;
      aIdx++;
    end else if (!chipEnable_n) begin
      seqLog.push_back({2'b00, ioOut});
    end
  end
  always @(negedge read_strobe_n) if (!chipEnable_n) begin
    #8;
    case (mode)
      0: ioIn = datByte(outPage, col);
      1: ioIn = {1'b1, {2{readyBusy_n}}, 5'h00};
      default: ioIn = ID_CODE[8*idIdx +: 8];
    endcase
  end
  always @(posedge read_strobe_n) if (!chipEnable_n) begin
    if (mode == 0) col++;
    else if (mode == 2) idIdx++;
    // Released bus must not look like a held copy
    #5 ioIn = ~ioIn;
  end
endmodule

// file: tb_top.sv
// Self-checking bench: nrtp_host driving a behavioural NAND model.
// Assumes 100 MHz core clock; inputs change on the falling edge.
module tb_top;
  import nrtp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [39:0] ID_CODE = 40'h1e2d3c4b5a; // Arbitrary value
  logic        core_clk, rst, opValid, opReady, wrValid, wrReady, rdValid;
  logic        waitBusy, cmdLatch, addrLatch, chipEnable_n, writeStrobe_n;
  logic        read_strobe_n, ioOe, readyBusy_n, holdBusy;
  nrtp_op_e    opCode;
  logic [39:0] addrA, addrB, a, b, r3;
  logic [11:0] dataLen, cl, c2;
  logic [15:0] pg;
  nrtp_byte_t  wrData, rdData, ioOut, ioIn;
  nrtp_byte_t  rdQ[$], wq[$];
  logic        wrTaken = 1'b0;
  logic [9:0]  expSeq[$];
  int          errorCnt = 0, nTests = 0, seed = 34;
  nrtp_host u_nrtp_host (.core_clk, .rst, .opValid, .opReady, .opCode, .addrA, .addrB,
    .dataLen, .wrValid, .wrReady, .wrData, .rdValid, .rdData, .waitBusy, .cmdLatch,
    .addrLatch, .chipEnable_n, .writeStrobe_n, .read_strobe_n, .ioOut, .ioOe, .ioIn,
    .readyBusy_n);
  nrtp_nand_model #(.ID_CODE(ID_CODE)) u_nrtp_nand_model (.cmdLatch, .addrLatch,
    .chipEnable_n, .writeStrobe_n, .read_strobe_n, .ioOut, .holdBusy, .ioIn, .readyBusy_n);
  always #5 core_clk = ~core_clk;
  // Hold each write byte until the sequencer takes it
  always @(negedge core_clk)
    if (!wrValid || wrTaken) begin
      wrData <= 8'($random(seed));
      wrValid <= 1'($random(seed));
    end
  always @(posedge core_clk) begin
    wrTaken <= wrValid && wrReady;
    if (wrValid && wrReady) wq.push_back(wrData);
  end
  always @(posedge core_clk)
    if (rdValid === 1'b1)
      cmp({2'b00, rdData}, rdQ.size() > 0 ? {2'b00, rdQ.pop_front()} : 10'h3ff);
  function automatic nrtp_byte_t dat(logic [15:0] p, logic [11:0] c);
    return nrtp_byte_t'(p[7:0] * 8'd29) ^ c[7:0] ^ {c[11:8], 4'h0};
  endfunction
  task automatic cmp(logic [9:0] got, logic [9:0] exp);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expRd(logic [15:0] p, logic [11:0] c, int n);
    for (int i = 0; i < n; i++) rdQ.push_back(dat(p, c + 12'(i)));
  endtask
  task automatic ec(nrtp_byte_t c);
    expSeq.push_back({2'b10, c});
  endtask
  task automatic ew();
    repeat (2) expSeq.push_back(wq.size() > 0 ? {2'b00, wq.pop_front()} : 10'h3ff);
  endtask
  task automatic ea(logic [39:0] x, int n);
    for (int i = 0; i < n; i++) expSeq.push_back({2'b01, x[8*i +: 8]});
  endtask
  task automatic chk();
    cmp(10'(u_nrtp_nand_model.seqLog.size()), 10'(expSeq.size()));
    if (u_nrtp_nand_model.seqLog.size() == expSeq.size())
      foreach (expSeq[i]) cmp(u_nrtp_nand_model.seqLog[i], expSeq[i]);
  endtask
  task automatic op(nrtp_op_e c, logic [39:0] x, logic [39:0] y, int n);
    int k;
    @(negedge core_clk);
    u_nrtp_nand_model.seqLog.delete();
    expSeq.delete();
    opCode = c;
    addrA = x;
    addrB = y;
    dataLen = 12'(n);
    opValid = 1'b1;
    k = 0;
    while (opReady !== 1'b0 && k < 100) begin
      @(negedge core_clk);
      k++;
    end
    opValid = 1'b0;
    while (opReady !== 1'b1 && k < 6000) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 6000) cmp(10'h000, 10'h001);
  endtask
  task automatic rb(int n);
    op(NRTP_OP_READBYTE, 40'h0, 40'h0, n);
    chk();
  endtask
  // Two-plane shape: c1, first addresses, c2 (11h adds 80h), second addresses, c3
  task automatic tp(nrtp_op_e c, nrtp_byte_t c1, nrtp_byte_t c2, nrtp_byte_t c3,
                    logic [39:0] x, logic [39:0] y, int n);
    op(c, x, y, 2);
    ec(c1);
    ea(x, n);
    if (c1 == 8'h80) ew();
    ec(c2);
    if (c2 == 8'h11) ec(8'h80);
    ea(y, n);
    if (c1 == 8'h80) ew();
    ec(c3);
    chk();
  endtask
  task automatic conclude();
    cmp(10'(rdQ.size()), 10'h000);
    if (errorCnt == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    errorCnt++;
    conclude();
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    opValid = 1'b0;
    opCode = NRTP_OP_PAGEREAD;
    addrA = 40'h0;
    addrB = 40'h0;
    dataLen = 12'h000;
    wrValid = 1'b0;
    wrData = 8'h00;
    holdBusy = 1'b0;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    pg = 16'($random(seed)) & 16'hffc0;
    cl = 12'($unsigned($random(seed)) % 2000);
    a = {8'h00, pg, 4'h0, cl};
    b = {8'h00, pg + 16'h0040, 4'h0, cl};
    r3 = {5{pg[7:0]}};
    op(NRTP_OP_PAGEREAD, a, 40'h0, 0);
    ec(8'h00);
    ea(a, 5);
    ec(8'h30);
    chk();
    expRd(pg, cl, 4);
    rb(4);
    rdQ.push_back(8'he0);
    op(NRTP_OP_STATUS, a, 40'h0, 1);
    expRd(pg, cl, 3);
    op(NRTP_OP_REREAD, a, 40'h0, 3);
    for (int i = 0; i < 3; i++) begin
      c2 = 12'($unsigned($random(seed)) % 2000);
      expRd(pg, c2, 3);
      op(NRTP_OP_RNDCOL, {28'h0, c2}, 40'h0, 3);
      ec(8'h05);
      ea({28'h0, c2}, 2);
      ec(8'he0);
      chk();
    end
    for (int i = 0; i < 3; i++) begin
      op(i < 2 ? NRTP_OP_CACHE : NRTP_OP_CACHELAST, a, 40'h0, 0);
      ec(i < 2 ? 8'h31 : 8'h3f);
      chk();
      expRd(pg + 16'(i), 12'h000, 2);
      rb(2);
    end
    for (int i = 0; i < 3; i++) rdQ.push_back(ID_CODE[8*i +: 8]);
    op(NRTP_OP_ID, 40'h0, 40'h0, 3);
    ec(8'h90);
    ea(40'h0, 1);
    chk();
    for (int i = 3; i < 5; i++) rdQ.push_back(ID_CODE[8*i +: 8]);
    rb(2);
    tp(NRTP_OP_TPREAD, 8'h00, 8'h00, 8'h30, a, b, 5);
    expRd(pg, cl, 2);
    op(NRTP_OP_TPRNDCOL, a, 40'h0, 2);
    ec(8'h06);
    ea(a, 5);
    ec(8'he0);
    chk();
    tp(NRTP_OP_TPCBREAD, 8'h00, 8'h00, 8'h35, a, b, 5);
    tp(NRTP_OP_TPCBPROG, 8'h85, 8'h11, 8'h10, a, b, 5);
    tp(NRTP_OP_TPPROG, 8'h80, 8'h11, 8'h10, a, b, 5);
    tp(NRTP_OP_TPCPROG, 8'h80, 8'h11, 8'h15, a, b, 5);
    tp(NRTP_OP_TPERASE, 8'h60, 8'h60, 8'hd0, r3, r3, 3);
    @(negedge core_clk);
    holdBusy = 1'b1;
    repeat (6) @(negedge core_clk);
    u_nrtp_nand_model.seqLog.delete();
    opCode = NRTP_OP_PAGEREAD;
    addrA = a;
    opValid = 1'b1;
    repeat (20) @(negedge core_clk);
    cmp({9'h000, opReady}, 10'h001);
    cmp(10'(u_nrtp_nand_model.seqLog.size()), 10'h000);
    opValid = 1'b0;
    rdQ.push_back(8'h80);
    op(NRTP_OP_PLSTAT, r3, 40'h0, 1);
    ec(8'h78);
    ea(r3, 3);
    chk();
    holdBusy = 1'b0;
    repeat (10) @(negedge core_clk);
    conclude();
  end
endmodule
